// ---- design/ift_pkg.sv ----
// constants, types and register map of the interrupt flag and trap control block
package ift_pkg;

    // ------------------------------------------------------------
    // register word indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL_ONE    = 4'h0;
    localparam logic [3:0]  ADDR_CTRL_TWO    = 4'h1;
    localparam logic [3:0]  ADDR_FLAGS_BASE  = 4'h2;
    localparam logic [3:0]  ADDR_IRQ_STATUS  = 4'h7;
    localparam logic [3:0]  ADDR_IRQ_MASK    = 4'h8;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int          REG_W            = 16;
    localparam int          FLAG_REGS        = 5;
    localparam int          EXT_INPUTS       = 5;
    localparam int          IRQ_BITS         = 6;
    localparam int          IRQ_TRAP_BIT     = 5;
    localparam int          SYNC_STAGES      = 3;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int          ADDR_FAULT_BIT   = 3;
    localparam int          STACK_FAULT_BIT  = 2;
    localparam int          OSC_LOSS_BIT     = 1;
    localparam int          ALT_VECTOR_BIT   = 15;
    localparam int          HOLD_INSTR_BIT   = 14;
    localparam logic [15:0] CTRL_ONE_MASK    = 16'h000E;
    localparam logic [15:0] CTRL_TWO_WMASK   = 16'h801F;
    localparam logic [15:0] CTRL_TWO_RMASK   = 16'hC01F;

    // ------------------------------------------------------------
    // flag register layouts
    // ------------------------------------------------------------
    localparam logic [15:0] FLAGS0_MASK      = 16'h7FFF;
    localparam logic [15:0] FLAGS1_MASK      = 16'hFF1F;
    localparam logic [15:0] FLAGS2_MASK      = 16'h007F;
    localparam logic [15:0] FLAGS2_NOCAN     = 16'h0073;
    localparam logic [15:0] FLAGS3_MASK      = 16'h0666;
    localparam logic [15:0] FLAGS4_MASK      = 16'h0A46;
    localparam logic [15:0] FLAGS4_NOCAN     = 16'h0A06;
    localparam int          EXT0_BIT         = 0;
    localparam int          EXT1_BIT         = 4;
    localparam int          EXT2_BIT         = 13;
    localparam int          EXT3_BIT         = 5;
    localparam int          EXT4_BIT         = 6;
    localparam int          COMPARE2_BIT     = 6;
    localparam int          TIMER2_BIT       = 7;
    localparam int          SERIAL1_BIT      = 9;
    localparam int          CAN_EVENT_BIT    = 3;
    localparam int          CAN_EXT_BIT      = 2;
    localparam int          PWM_MATCH_BIT    = 9;
    localparam int          UART2_ERR_BIT    = 2;
    localparam int          UART1_ERR_BIT    = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_WORD       = 16'h0000;
    localparam logic [31:0] RESET_DATA       = 32'h0000_0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] four;
        logic [15:0] three;
        logic [15:0] two;
        logic [15:0] one;
        logic [15:0] zero;
    } ift_flags_t;

    typedef struct packed {
        logic address_fault;
        logic stack_fault;
        logic osc_loss;
    } ift_trap_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } ift_bus_state_t;

endpackage

// ---- design/ift_edge_det.sv ----
// synchroniser and selectable edge detector for the external interrupt inputs
`timescale 1ns/100ps
`default_nettype none
module ift_edge_det #(
    parameter int N = 5
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rst_n_in,
    input  wire logic [N-1:0] pin_in,
    input  wire logic [N-1:0] falling_sel_in,
    output logic      [N-1:0] edge_out
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic level_reg;
            logic pulse_reg;

            always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                end else begin
                    s1_reg <= pin_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                end
            end

            // (RULE6) polarity edge select
            always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    level_reg <= 1'b0;
                    pulse_reg <= 1'b0;
                end else begin
                    pulse_reg <= 1'b0;
                    if ((s2_reg == s3_reg) && (s2_reg != level_reg)) begin
                        level_reg <= s2_reg;
                        pulse_reg <= falling_sel_in[i] ? ~s2_reg : s2_reg;
                    end
                end
            end

            assign edge_out[i] = pulse_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- design/ift_ctrl.sv ----
// register file for trap status, interrupt control and request flags
`timescale 1ns/100ps
`default_nettype none

// Operation
// (RULE1) address fault trap sets control one bit 3, else reads zero
// (RULE2) stack fault trap sets control one bit 2, else reads zero
// (RULE3) oscillator loss trap sets control one bit 1, else reads zero
// (RULE4) control two bit 15 selects alternate vector table when one
// (RULE5) control two bits 4..0 hold edge polarity for external inputs 0..4
// (RULE6) polarity one requests on falling edge, zero on rising edge
// (RULE7) implemented flags read one once requested, are read/write, reset zero
// (RULE8) unimplemented bits read zero and ignore writes
// (RULE9) flags zero: external 0 bit 0, capture 1 bit 1, compare 1 bit 2
// (RULE10) flags zero: compare 2 at bit 6, timer 2 at bit 7
// (RULE11) flags zero: serial fault at bit 9, bit 15 unimplemented
// (RULE12) flags two: CAN event bit 3, CAN external bit 2, absent without CAN
// (RULE13) flags three bit 9 set on PWM special event match
// (RULE14) flags three bit 5 set on selected edge of external input 3
// (RULE15) flags four: second UART error bit 2, first UART error bit 1
// (RULE16) hardware only sets flags; software clears them by writing
// (RULE17) control two bit 14 reads one while interrupt hold instruction active
// (RULE18) trap bits stay set until software writes them to zero
module ift_ctrl
    import ift_pkg::*;
#(
    parameter bit CAN_PRESENT = 1'b1
) (
    input  wire logic                clk_sys_in,
    input  wire logic                rst_n_in,
    input  wire logic [3:0]          avs_address_in,
    input  wire logic                avs_read_in,
    input  wire logic                avs_write_in,
    input  wire logic [31:0]         avs_writedata_in,
    input  wire logic [3:0]          avs_byteenable_in,
    output logic      [31:0]         avs_readdata_out,
    output logic                     avs_waitrequest_out,
    input  wire ift_pkg::ift_flags_t periph_set_in,
    input  wire ift_pkg::ift_trap_t  trap_set_in,
    input  wire logic                irq_hold_instr_active_in,
    input  wire logic [4:0]          ext_pin_in,
    output ift_pkg::ift_flags_t      flags_out,
    output logic                     alt_vector_table_select_out,
    output logic                     irq_out
);
    import ift_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ift_bus_state_t                 bus_state_reg;
    logic                           waitrequest_reg;
    logic [31:0]                    readdata_reg;
    logic [31:0]                    readdata_next;
    logic [15:0]                    ctrl_one_reg;
    logic [15:0]                    ctrl_one_next;
    logic                           alt_vector_reg;
    logic                           hold_instr_reg;
    logic [4:0]                     polarity_reg;
    logic [FLAG_REGS-1:0][15:0]     flags_reg;
    logic [FLAG_REGS-1:0][15:0]     impl_mask;
    logic [FLAG_REGS-1:0][15:0]     ext_pos_mask;
    logic [FLAG_REGS-1:0][15:0]     ext_set;
    logic [FLAG_REGS-1:0][15:0]     periph_bits;
    logic [FLAG_REGS-1:0][15:0]     hw_set;
    logic [IRQ_BITS-1:0]            irq_status_reg;
    logic [IRQ_BITS-1:0]            irq_status_next;
    logic [IRQ_BITS-1:0]            irq_mask_reg;
    logic [IRQ_BITS-1:0]            irq_event;
    logic                           irq_reg;
    logic [4:0]                     ext_edge;
    logic [15:0]                    wmask;
    logic [15:0]                    wdata;
    logic                           wr_hit;
    logic [FLAG_REGS-1:0]           flag_sel;

    // ------------------------------------------------------------
    // external input edge detection
    // ------------------------------------------------------------
    ift_edge_det #(
        .N (EXT_INPUTS)
    ) u_edge (
        .clk_sys_in     (clk_sys_in),
        .rst_n_in       (rst_n_in),
        .pin_in         (ext_pin_in),
        .falling_sel_in (polarity_reg),
        .edge_out       (ext_edge)
    );

    // ------------------------------------------------------------
    // layout masks and set sources
    // ------------------------------------------------------------
    // (RULE8) implemented bit masks
    // (RULE11) flags zero top bit absent
    // (RULE12) CAN bits removed without CAN
    assign impl_mask[0] = FLAGS0_MASK;
    assign impl_mask[1] = FLAGS1_MASK;
    assign impl_mask[2] = CAN_PRESENT ? FLAGS2_MASK : FLAGS2_NOCAN;
    assign impl_mask[3] = FLAGS3_MASK;
    assign impl_mask[4] = CAN_PRESENT ? FLAGS4_MASK : FLAGS4_NOCAN;

    // (RULE14) external edges to flag positions
    // (RULE9) external 0 at flags zero bit 0
    always_comb begin
        ext_set      = '0;
        ext_pos_mask = '0;
        ext_set[0][EXT0_BIT]      = ext_edge[0];
        ext_set[1][EXT1_BIT]      = ext_edge[1];
        ext_set[1][EXT2_BIT]      = ext_edge[2];
        ext_set[3][EXT3_BIT]      = ext_edge[3];
        ext_set[3][EXT4_BIT]      = ext_edge[4];
        ext_pos_mask[0][EXT0_BIT] = 1'b1;
        ext_pos_mask[1][EXT1_BIT] = 1'b1;
        ext_pos_mask[1][EXT2_BIT] = 1'b1;
        ext_pos_mask[3][EXT3_BIT] = 1'b1;
        ext_pos_mask[3][EXT4_BIT] = 1'b1;
    end

    // (RULE10) peripheral requests land at their bit positions
    // (RULE13) PWM match sets flags three bit 9
    // (RULE15) UART errors set flags four bits 2 and 1
    assign periph_bits = periph_set_in;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign wr_hit = (bus_state_reg == BUS_ACK) && avs_write_in;
    assign wmask  = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    assign wdata  = avs_writedata_in[15:0];

    always_comb begin
        readdata_next = RESET_DATA;
        case (avs_address_in)
            ADDR_CTRL_ONE: begin
                readdata_next[15:0] = ctrl_one_reg & CTRL_ONE_MASK;
            end
            ADDR_CTRL_TWO: begin
                readdata_next[ALT_VECTOR_BIT] = alt_vector_reg;
                readdata_next[HOLD_INSTR_BIT] = hold_instr_reg;
                readdata_next[4:0]            = polarity_reg;
            end
            ADDR_IRQ_STATUS: begin
                readdata_next[IRQ_BITS-1:0] = irq_status_reg;
            end
            ADDR_IRQ_MASK: begin
                readdata_next[IRQ_BITS-1:0] = irq_mask_reg;
            end
            default: begin
                for (int k = 0; k < FLAG_REGS; k++) begin
                    if (avs_address_in == ADDR_FLAGS_BASE + 4'(k)) begin
                        readdata_next[15:0] = flags_reg[k] & impl_mask[k];
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // bus slave state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_state_reg   <= BUS_IDLE;
            waitrequest_reg <= 1'b1;
            readdata_reg    <= RESET_DATA;
        end else begin
            case (bus_state_reg)
                BUS_IDLE: begin
                    if (avs_read_in || avs_write_in) begin
                        bus_state_reg   <= BUS_ACK;
                        waitrequest_reg <= 1'b0;
                        readdata_reg    <= avs_read_in ? readdata_next : RESET_DATA;
                    end
                end
                BUS_ACK: begin
                    bus_state_reg   <= BUS_IDLE;
                    waitrequest_reg <= 1'b1;
                end
                default: begin
                    bus_state_reg   <= BUS_IDLE;
                    waitrequest_reg <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // control register one: trap status
    // ------------------------------------------------------------
    always_comb begin
        ctrl_one_next = ctrl_one_reg;
        if (wr_hit && (avs_address_in == ADDR_CTRL_ONE)) begin
            ctrl_one_next = (ctrl_one_reg & ~wmask) | (wdata & wmask);
        end
        // (RULE1) address fault sets bit 3
        ctrl_one_next[ADDR_FAULT_BIT]  = ctrl_one_next[ADDR_FAULT_BIT] | trap_set_in.address_fault;
        // (RULE2) stack fault sets bit 2
        ctrl_one_next[STACK_FAULT_BIT] = ctrl_one_next[STACK_FAULT_BIT] | trap_set_in.stack_fault;
        // (RULE3) oscillator loss sets bit 1
        ctrl_one_next[OSC_LOSS_BIT]    = ctrl_one_next[OSC_LOSS_BIT] | trap_set_in.osc_loss;
        ctrl_one_next = ctrl_one_next & CTRL_ONE_MASK;
    end

    // (RULE18) trap bits held until written
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_one_reg <= RESET_WORD;
        end else begin
            ctrl_one_reg <= ctrl_one_next;
        end
    end

    // ------------------------------------------------------------
    // control register two
    // ------------------------------------------------------------
    // (RULE4) vector table select
    // (RULE5) polarity bits stored
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alt_vector_reg <= 1'b0;
            polarity_reg   <= 5'h00;
        end else if (wr_hit && (avs_address_in == ADDR_CTRL_TWO)) begin
            if (wmask[ALT_VECTOR_BIT] && CTRL_TWO_WMASK[ALT_VECTOR_BIT]) begin
                alt_vector_reg <= wdata[ALT_VECTOR_BIT];
            end
            polarity_reg <= (polarity_reg & ~wmask[4:0]) | (wdata[4:0] & wmask[4:0]);
        end
    end

    // (RULE17) hold instruction status tracks core
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hold_instr_reg <= 1'b0;
        end else begin
            hold_instr_reg <= irq_hold_instr_active_in;
        end
    end

    // ------------------------------------------------------------
    // request flag registers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < FLAG_REGS; g++) begin : g_flags
            logic [15:0] flag_next;

            assign flag_sel[g] = wr_hit && (avs_address_in == ADDR_FLAGS_BASE + 4'(g));
            assign hw_set[g]   = ((periph_bits[g] & ~ext_pos_mask[g]) | ext_set[g])
                                 & impl_mask[g];
            assign irq_event[g] = |(hw_set[g] & ~flags_reg[g]);

            // (RULE7) software write then hardware set
            // (RULE16) set wins over software clear
            always_comb begin
                flag_next = flags_reg[g];
                if (flag_sel[g]) begin
                    flag_next = (flags_reg[g] & ~wmask) | (wdata & wmask);
                end
                flag_next = (flag_next | hw_set[g]) & impl_mask[g];
            end

            always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    flags_reg[g] <= RESET_WORD;
                end else begin
                    flags_reg[g] <= flag_next;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------
    assign irq_event[IRQ_TRAP_BIT] = |(ctrl_one_next & ~ctrl_one_reg);

    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_hit && (avs_address_in == ADDR_IRQ_STATUS) && avs_byteenable_in[0]) begin
            irq_status_next = irq_status_reg & ~avs_writedata_in[IRQ_BITS-1:0];
        end
        irq_status_next = irq_status_next | irq_event;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_status_reg <= '0;
            irq_mask_reg   <= '0;
            irq_reg        <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            if (wr_hit && (avs_address_in == ADDR_IRQ_MASK) && avs_byteenable_in[0]) begin
                irq_mask_reg <= avs_writedata_in[IRQ_BITS-1:0];
            end
            irq_reg <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata_out            = readdata_reg;
    assign avs_waitrequest_out         = waitrequest_reg;
    assign flags_out                   = flags_reg;
    assign alt_vector_table_select_out = alt_vector_reg;
    assign irq_out                     = irq_reg;
endmodule
`default_nettype wire

// ---- testbench/ift_ctrl_assertions.sv ----
// port checks for the interrupt flag and trap control block
`timescale 1ns/100ps
`default_nettype none
module ift_ctrl_assertions
    import ift_pkg::*;
(
    input wire logic                clk_sys_in,
    input wire logic                rst_n_in,
    input wire logic                avs_write_in,
    input wire logic [31:0]         avs_readdata_out,
    input wire logic                avs_waitrequest_out,
    input wire ift_pkg::ift_flags_t periph_set_in,
    input wire ift_pkg::ift_flags_t flags_out,
    input wire logic                alt_vector_table_select_out
);
    localparam logic [79:0] IMPL = {FLAGS4_MASK, FLAGS3_MASK, FLAGS2_MASK, FLAGS1_MASK,
                                    FLAGS0_MASK};
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // ------------------------------------------------------------
    // flag placement, setting and holding, read data upper half and vector select
    // ------------------------------------------------------------
    capture_compare_a: assert property (&periph_set_in.zero[2:1] |=> &flags_out.zero[2:1])
        else $error("capture or compare flag not set");
    timer_compare_a: assert property (&periph_set_in.zero[7:6] |=> &flags_out.zero[7:6])
        else $error("timer or compare flag not set");
    serial_fault_a: assert property (periph_set_in.zero[9] |=> flags_out.zero[9])
        else $error("serial fault flag not set");
    can_event_a: assert property (&periph_set_in.two[3:2] |=> &flags_out.two[3:2])
        else $error("can flags not set");
    pwm_match_a: assert property (periph_set_in.three[9] |=> flags_out.three[9])
        else $error("pwm match flag not set");
    uart_error_a: assert property (&periph_set_in.four[2:1] |=> &flags_out.four[2:1])
        else $error("uart error flags not set");
    flag_hold_a: assert property (
        flags_out.three[9] && !avs_write_in |=> flags_out.three[9])
        else $error("flag cleared without a write");
    unimpl_zero_a: assert property ((flags_out & ~IMPL) == 80'h0)
        else $error("unimplemented flag bit set");
    read_upper_a: assert property (
        !avs_waitrequest_out |-> avs_readdata_out[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    alt_by_write_a: assert property (
        $changed(alt_vector_table_select_out) |-> $past(avs_write_in))
        else $error("vector select changed without a write");
    cover property (periph_set_in.zero[9]);
    cover property (!avs_waitrequest_out && avs_write_in);
    cover property ($rose(alt_vector_table_select_out));
endmodule
`default_nettype wire

// ---- testbench/ift_source_model.sv ----
// peripheral request sources, trap sources and core status
`timescale 1ns/100ps
`default_nettype none
module ift_source_model
    import ift_pkg::*;
(
    input  wire logic          clk_sys_in,
    output ift_pkg::ift_flags_t periph_set_out,
    output ift_pkg::ift_trap_t  trap_set_out,
    output logic               hold_active_out,
    output logic [4:0]         pin_out
);
    initial begin
        periph_set_out = '0;
        trap_set_out = '0;
        hold_active_out = 1'b0;
        pin_out = 5'h00;
    end
    task automatic pulse(input ift_flags_t f, input ift_trap_t t);
        @(posedge clk_sys_in);
        periph_set_out <= f;
        trap_set_out <= t;
        @(posedge clk_sys_in);
        periph_set_out <= '0;
        trap_set_out <= '0;
    endtask
    task automatic drive(input logic h, input logic [4:0] p);
        @(posedge clk_sys_in);
        hold_active_out <= h;
        pin_out <= p;
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb_ift_ctrl.sv ----
// self-checking bench for the interrupt flag and trap control block
`timescale 1ns/100ps
`default_nettype none
module tb_ift_ctrl;
    import ift_pkg::*;
    logic               clk_sys_in;
    logic               rst_n_in;
    logic [3:0]         avs_address;
    logic               avs_read;
    logic               avs_write;
    logic [31:0]        avs_writedata;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic [31:0]        rbuf;
    ift_flags_t         periph_set;
    ift_flags_t         flags;
    ift_trap_t          trap_set;
    logic               hold_act;
    logic [4:0]         pins;
    logic               alt_sel;
    logic               irq;
    int                 mismatches;
    int                 num_checks;
    int                 cycles;
    logic [15:0]        impl [5] = '{FLAGS0_MASK, FLAGS1_MASK, FLAGS2_MASK, FLAGS3_MASK,
                                     FLAGS4_MASK};
    logic [15:0]        ext  [5] = '{16'h0001, 16'h2010, 16'h0000, 16'h0060, 16'h0000};

    ift_ctrl dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address),
        .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest), .periph_set_in(periph_set),
        .trap_set_in(trap_set), .irq_hold_instr_active_in(hold_act), .ext_pin_in(pins),
        .flags_out(flags), .alt_vector_table_select_out(alt_sel), .irq_out(irq));
    ift_source_model src_u (.clk_sys_in(clk_sys_in), .periph_set_out(periph_set),
        .trap_set_out(trap_set), .hold_active_out(hold_act), .pin_out(pins));

    // ------------------------------------------------------------
    // clock, timeout, helpers
    // ------------------------------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk_sys_in);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys_in);
        rbuf = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk(rbuf, {16'h0000, e});
    endtask
    task automatic ext_chk(input logic on);
        for (int i = 0; i < 4; i++) begin
            rd_chk(ADDR_FLAGS_BASE + i[3:0], on ? ext[i] : 16'h0000);
            bus(1'b1, ADDR_FLAGS_BASE + i[3:0], 16'h0000);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n_in = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        repeat (5) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 10; i++) rd_chk(i[3:0], 16'h0000);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, ADDR_FLAGS_BASE + i[3:0], 16'hFFFF);
            rd_chk(ADDR_FLAGS_BASE + i[3:0], impl[i]);
            bus(1'b1, ADDR_FLAGS_BASE + i[3:0], 16'h0000);
            rd_chk(ADDR_FLAGS_BASE + i[3:0], 16'h0000);
        end
        bus(1'b1, ADDR_IRQ_STATUS, 16'h003F);
        bus(1'b1, ADDR_IRQ_MASK, 16'h0000);
        src_u.pulse('1, '0);
        repeat (4) @(posedge clk_sys_in);
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            rd_chk(ADDR_FLAGS_BASE + i[3:0], impl[i] & ~ext[i]);
        end
        bus(1'b1, ADDR_IRQ_MASK, 16'h003F);
        repeat (2) @(posedge clk_sys_in);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, ADDR_IRQ_STATUS, 16'h003F);
        repeat (2) @(posedge clk_sys_in);
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < 5; i++) bus(1'b1, ADDR_FLAGS_BASE + i[3:0], 16'h0000);
        bus(1'b1, ADDR_CTRL_ONE, 16'hFFFF);
        rd_chk(ADDR_CTRL_ONE, 16'h000E);
        bus(1'b1, ADDR_CTRL_ONE, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            src_u.pulse('0, 3'b100 >> i);
            repeat (3) @(posedge clk_sys_in);
            rd_chk(ADDR_CTRL_ONE, 16'h0008 >> i);
            bus(1'b1, ADDR_CTRL_ONE, 16'h0000);
            rd_chk(ADDR_CTRL_ONE, 16'h0000);
        end
        bus(1'b1, ADDR_CTRL_TWO, 16'hFFFF);
        rd_chk(ADDR_CTRL_TWO, 16'h801F);
        chk({31'h0, alt_sel}, 32'h1);
        src_u.drive(1'b1, 5'h00);
        rd_chk(ADDR_CTRL_TWO, 16'hC01F);
        src_u.drive(1'b0, 5'h00);
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, ADDR_CTRL_TWO, (p == 1) ? 16'h001F : 16'h0000);
            src_u.drive(1'b0, 5'h1F);
            repeat (8) @(posedge clk_sys_in);
            ext_chk(p == 0);
            src_u.drive(1'b0, 5'h00);
            repeat (8) @(posedge clk_sys_in);
            ext_chk(p == 1);
        end
        chk({31'h0, alt_sel}, 32'h0);
        summarize();
    end
endmodule

bind ift_ctrl ift_ctrl_assertions chk_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .periph_set_in(periph_set_in),
    .flags_out(flags_out), .alt_vector_table_select_out(alt_vector_table_select_out));
`default_nettype wire
